// File: pkg/srr_pkg.sv
package srr_pkg;
	// ----------------------------------------------------------------
	// Command opcodes
	// ----------------------------------------------------------------
	localparam logic [7:0] OP_WR_EN    = 8'h06;
	localparam logic [7:0] OP_WR_DIS   = 8'h04;
	localparam logic [7:0] OP_RD_SR1   = 8'h05;
	localparam logic [7:0] OP_RD_SR2   = 8'h35;
	localparam logic [7:0] OP_PROG_SEC = 8'h42;
	localparam logic [7:0] OP_READ_SEC = 8'h48;
	localparam logic [7:0] OP_RST_EN   = 8'h66;
	localparam logic [7:0] OP_RST_DEV  = 8'h99;

	// ----------------------------------------------------------------
	// Array geometry, reset values and timing
	// ----------------------------------------------------------------
	localparam int          SEC_REG_BYTES = 512;
	localparam int          SEC_REG_COUNT = 3;
	localparam int          FIFO_DEPTH    = 4;
	localparam logic [10:0] MEM_LAST      = 11'(SEC_REG_COUNT * SEC_REG_BYTES - 1);
	localparam logic [7:0]  PAGE_LAST     = 8'hFF;
	localparam logic [7:0]  ERASED_BYTE   = 8'hFF;
	localparam logic [1:0]  ADDR_LAST     = 2'h2;
	localparam logic [7:0]  CONT_READ_RST = 8'h00;
	localparam logic [2:0]  WRAP_RST      = 3'h0;
	localparam int          SYS_CLK_MHZ   = 40;
	localparam int          PROG_TIME_NS  = 1_000_000;
	localparam int          RST_TIME_NS   = 30_000;
	localparam int          PROG_CYCLES   = (PROG_TIME_NS * SYS_CLK_MHZ + 999) / 1000;
	localparam int          RST_CYCLES    = (RST_TIME_NS * SYS_CLK_MHZ + 999) / 1000;
	localparam int          END_SETTLE    = 3;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {BK_OPCODE, BK_ADDR, BK_DATA} srr_kind_e;
	typedef struct packed {
		srr_kind_e  kind;
		logic [7:0] data;
	} srr_byte_s;
	typedef struct packed {
		logic       busy;
		logic       write_enable_latch;
		logic       suspend_flag;
		logic       recov;
		logic [2:0] lock;
	} srr_stat_s;

	// Returns 1..3 for a legal security register address, 0 otherwise.
	function automatic logic [1:0] sec_sel(input logic [23:0] a);
		sec_sel = 2'h0;
		if (a[23:16] == 8'h00 && a[11:9] == 3'h0 && a[15:14] == 2'h0 && a[13:12] != 2'h0) begin
			sec_sel = a[13:12];
		end
	endfunction
endpackage

// File: core/srr_top.sv
// Summary of operation
// - Program opcode 42h is refused unless the write enable latch is set.
// - Each register is 512 bytes, programmed 256 bytes at a time into erased cells.
// - Address: top byte zero, bits 15-12 pick register 1-3, 11-9 zero.
// - Read is 48h, 24-bit address, eight dummy clocks, then sequential data.
// - Inputs taken on rising clock, data shifted out on falling clock, MSB first.
// - Read address advances each byte and wraps from FFh to 00h.
// - A read runs until chip select goes high.
// - A read arriving while busy is ignored and leaves the cycle alone.
// - Programs to a register whose lock bit is set are ignored.
// - Software reset aborts work and clears latch, suspend, mode and wrap bits.
// - Reset needs 99h straight after 66h; anything else disarms.
// - No command is taken during reset recovery.
// - Busy reads one during a self-timed cycle and zero after it.
// - Lock bits sit at status bits 13-11, registers three down to one.

module srr_fifo #(
	parameter int WIDTH = 10, // Word width.
	parameter int DEPTH = 4   // Number of words.
) (
	input  wire logic             i_clk,   // Clock.
	input  wire logic             i_rst,   // Synchronous reset.
	input  wire logic [WIDTH-1:0] i_data,  // Write word.
	input  wire logic             i_valid, // Write request.
	output logic                  o_ready, // Room for a word.
	output logic      [WIDTH-1:0] o_data,  // Oldest word.
	output logic                  o_valid, // A word is held.
	input  wire logic             i_ready  // Reader takes the word.
);
	localparam int             AW   = $clog2(DEPTH);
	localparam int             CW   = $clog2(DEPTH + 1);
	localparam logic [AW-1:0]  LAST = AW'(DEPTH - 1);
	localparam logic [CW-1:0]  FULL = CW'(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wp_r;
	logic [AW-1:0]    rp_r;
	logic [CW-1:0]    cnt_r;
	logic             push;
	logic             pop;

	// Handshakes on both sides; full and empty come from one counter.
	assign o_ready = (cnt_r != FULL);
	assign o_valid = (cnt_r != '0);
	assign o_data  = mem_r[rp_r];
	assign push    = i_valid & o_ready;
	assign pop     = o_valid & i_ready;

	// Storage writes only.
	always_ff @(posedge i_clk) begin
		if (push) begin
			mem_r[wp_r] <= i_data;
		end
	end

	// Pointers and fill level.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			if (push) begin
				wp_r <= (wp_r == LAST) ? '0 : wp_r + AW'(1);
			end
			if (pop) begin
				rp_r <= (rp_r == LAST) ? '0 : rp_r + AW'(1);
			end
			cnt_r <= cnt_r + CW'(push) - CW'(pop);
		end
	end
endmodule

module srr_top #(
	parameter int PROG_CYCLES = srr_pkg::PROG_CYCLES // Program busy time in clocks.
) (
	input  wire logic       I_SYS_CLK,           // System clock, 40 MHz.
	input  wire logic       I_RST,               // Reset, active high; synchronous on the system clock, asynchronous in the byte hand-off.
	input  wire logic       I_SCK,               // Serial clock from the host.
	input  wire logic       I_CS_N,              // Chip select, active low.
	input  wire logic       I_SI,                // Serial data in.
	output logic            O_SO,                // Serial data out.
	output logic            O_SO_OE,             // Serial out enable.
	input  wire logic [2:0] I_OTP_LOCK_SET,      // Pulses that set lock bits.
	input  wire logic       I_VOL_LOAD,          // Loads the volatile settings.
	input  wire logic       I_SUSPEND_FLAG,      // Suspend value to load.
	input  wire logic [7:0] I_CONT_READ_BITS,    // Mode bits to load.
	input  wire logic [2:0] I_WRAP_SETTING_BITS, // Wrap bits to load.
	output logic            O_BUSY_FLAG,         // Self-timed cycle running.
	output logic            O_WRITE_ENABLE_LATCH, // Write enable latch.
	output logic            O_SUSPEND_FLAG,      // Suspend state.
	output logic [2:0]      O_OTP_LOCK_BITS,     // Lock bits, register 3..1.
	output logic [7:0]      O_CONT_READ_BITS,    // Continuous read mode bits.
	output logic [2:0]      O_WRAP_SETTING_BITS, // Wrap setting bits.
	output logic            O_RECOVERING         // Reset recovery running.
);
	typedef enum {PH_OPC, PH_ADDR, PH_DUMMY, PH_DATA, PH_SEC, PH_SR1, PH_SR2, PH_IGN} srr_phase_e;
	typedef enum {ST_INIT, ST_IDLE, ST_COMMIT, ST_WAIT, ST_RECOVER} srr_state_e;

	logic [7:0]         mem_r [srr_pkg::SEC_REG_COUNT * srr_pkg::SEC_REG_BYTES];
	logic [7:0]         pbuf_r [256];
	// ----------------------------------------------------------------
	// Serial clock domain
	// ----------------------------------------------------------------
	srr_phase_e         phase_r;
	logic [2:0]         bit_cnt_r;
	logic [6:0]         sh_r;
	logic [15:0]        addr_r;
	logic [1:0]         acnt_r;
	logic               is_read_r;
	logic [8:0]         rd_addr_r;
	logic [1:0]         rd_sel_r;
	logic [7:0]         out_sh_r;
	logic               so_r;
	logic               so_oe_r;
	logic               tog_r;
	logic               partial_r;
	srr_pkg::srr_byte_s hold_r [2];
	logic [6:0]         ks1_r, ks2_r, ks3_r, ksf_r;
	srr_pkg::srr_stat_s kstat;
	logic [6:0]         stat_r; // Status word, written on the system clock.
	logic [7:0]         byte_in;
	logic [23:0]        full_in;
	logic [7:0]         obyte;

	assign byte_in = {sh_r, I_SI};
	assign full_in = {addr_r, byte_in};
	assign kstat   = srr_pkg::srr_stat_s'(ksf_r);

	// Frame decode on rising edges; chip select high ends the frame.
	always_ff @(posedge I_SCK or posedge I_CS_N) begin
		if (I_CS_N) begin
			phase_r   <= PH_OPC;
			bit_cnt_r <= 3'h0;
			sh_r      <= 7'h00;
			acnt_r    <= 2'h0;
			is_read_r <= 1'b0;
		end else begin
			bit_cnt_r <= bit_cnt_r + 3'h1;
			sh_r      <= byte_in[6:0];
			if (bit_cnt_r == 3'h7) begin
				case (phase_r)
					PH_OPC: begin
						is_read_r <= (byte_in == srr_pkg::OP_READ_SEC);
						if (kstat.recov) begin
							phase_r <= PH_IGN;
						end else if (byte_in == srr_pkg::OP_RD_SR1) begin
							phase_r <= PH_SR1;
						end else if (byte_in == srr_pkg::OP_RD_SR2) begin
							phase_r <= PH_SR2;
						end else if (byte_in == srr_pkg::OP_READ_SEC) begin
							phase_r <= kstat.busy ? PH_IGN : PH_ADDR;
						end else if (byte_in == srr_pkg::OP_PROG_SEC) begin
							phase_r <= PH_ADDR;
						end else begin
							phase_r <= PH_IGN;
						end
					end
					PH_ADDR: begin
						acnt_r <= acnt_r + 2'h1;
						if (acnt_r == srr_pkg::ADDR_LAST) begin
							if (!is_read_r) begin
								phase_r <= PH_DATA;
							end else if (srr_pkg::sec_sel(full_in) != 2'h0) begin
								phase_r <= PH_DUMMY;
							end else begin
								phase_r <= PH_IGN;
							end
						end
					end
					PH_DUMMY: phase_r <= PH_SEC;
					default: phase_r <= phase_r;
				endcase
			end
		end
	end

	// Address capture and read address walk; stays within one 256-byte half.
	always_ff @(posedge I_SCK) begin
		if (!I_CS_N && bit_cnt_r == 3'h7) begin
			if (phase_r == PH_ADDR) begin
				addr_r    <= full_in[15:0];
				rd_addr_r <= full_in[8:0];
				rd_sel_r  <= srr_pkg::sec_sel(full_in);
			end else if (phase_r == PH_SEC) begin
				rd_addr_r <= {rd_addr_r[8], rd_addr_r[7:0] + 8'h01};
			end
		end
	end

	// Read data selection for the byte about to be shifted out.
	always_comb begin
		case (phase_r)
			PH_SR1: obyte = {6'h00, kstat.write_enable_latch, kstat.busy};
			PH_SR2: obyte = {kstat.suspend_flag, 1'b0, kstat.lock, 3'h0};
			PH_SEC: obyte = mem_r[{2'(rd_sel_r - 2'h1), rd_addr_r}];
			default: obyte = 8'h00;
		endcase
	end

	// Falling-edge shifter; output runs until select rises.
	always_ff @(negedge I_SCK or posedge I_CS_N) begin
		if (I_CS_N) begin
			so_r     <= 1'b0;
			so_oe_r  <= 1'b0;
			out_sh_r <= 8'h00;
		end else if (bit_cnt_r == 3'h0 &&
				(phase_r == PH_SEC || phase_r == PH_SR1 || phase_r == PH_SR2)) begin
			so_oe_r  <= 1'b1;
			so_r     <= obyte[7];
			out_sh_r <= {obyte[6:0], 1'b0};
		end else begin
			so_r     <= out_sh_r[7];
			out_sh_r <= {out_sh_r[6:0], 1'b0};
		end
	end

	// Byte hand-off: two slots alternate so each is stable for two byte times.
	always_ff @(posedge I_SCK or posedge I_RST) begin
		if (I_RST) begin
			tog_r     <= 1'b0;
			partial_r <= 1'b0;
			hold_r[0] <= '0;
			hold_r[1] <= '0;
			ks1_r     <= 7'h00;
			ks2_r     <= 7'h00;
			ks3_r     <= 7'h00;
			ksf_r     <= 7'h00;
		end else begin
			partial_r <= (bit_cnt_r != 3'h7);
			ks1_r     <= stat_r;
			ks2_r     <= ks1_r;
			ks3_r     <= ks2_r;
			ksf_r     <= (ks2_r & ks3_r) | (ksf_r & (ks2_r ^ ks3_r));
			if (!I_CS_N && bit_cnt_r == 3'h7 &&
					(phase_r == PH_OPC || phase_r == PH_ADDR || phase_r == PH_DATA)) begin
				hold_r[tog_r].data <= byte_in;
				hold_r[tog_r].kind <= (phase_r == PH_OPC) ? srr_pkg::BK_OPCODE :
				                      (phase_r == PH_ADDR) ? srr_pkg::BK_ADDR : srr_pkg::BK_DATA;
				tog_r <= ~tog_r;
			end
		end
	end

	// ----------------------------------------------------------------
	// System clock domain
	// ----------------------------------------------------------------
	srr_state_e         state_r;
	logic [2:0]         sy1_r, sy2_r, sy3_r, syf_r;
	logic               cs_prev_r;
	logic               ack_r;
	logic               rx_valid_r;
	srr_pkg::srr_byte_s rx_r;
	srr_pkg::srr_byte_s ev;
	logic               ev_valid, rx_ready, pop, is_op, do_reset, start_commit;
	logic [10:0]        cnt_r;
	logic [31:0]        timer_r;
	logic [7:0]         op_r;
	logic               prog_ok_r, got_r, end_pend_r, page_r;
	logic [1:0]         pacnt_r, psel_r, end_wait_r;
	logic [15:0]        paddr_r;
	logic [7:0]         bidx_r;
	logic [255:0]       pval_r;
	logic               wel_r, sus_r, armed_r, busy_r, recov_r;
	logic [2:0]         lock_r;
	logic [7:0]         cont_r;
	logic [2:0]         wrap_r;
	logic [23:0]        paddr_full;
	logic               eng_ready;
	logic               prog_end;

	assign eng_ready  = (state_r != ST_COMMIT) && (state_r != ST_INIT);
	assign pop        = ev_valid & eng_ready;
	assign is_op      = pop && ev.kind == srr_pkg::BK_OPCODE && state_r != ST_RECOVER;
	assign do_reset   = is_op && ev.data == srr_pkg::OP_RST_DEV && armed_r;
	assign paddr_full = {paddr_r, ev.data};
	assign prog_end   = (state_r == ST_WAIT) && (timer_r == 32'(PROG_CYCLES - 1));
	assign start_commit = end_pend_r && end_wait_r == 2'(srr_pkg::END_SETTLE) && !ev_valid &&
	                      !rx_valid_r && op_r == srr_pkg::OP_PROG_SEC && prog_ok_r && got_r &&
	                      !syf_r[2] && state_r == ST_IDLE;

	// Three-stage filters for select, hand-off toggle and byte-boundary flag.
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST) begin
			sy1_r     <= 3'h1;
			sy2_r     <= 3'h1;
			sy3_r     <= 3'h1;
			syf_r     <= 3'h1;
			cs_prev_r <= 1'b1;
		end else begin
			sy1_r     <= {partial_r, tog_r, I_CS_N};
			sy2_r     <= sy1_r;
			sy3_r     <= sy2_r;
			syf_r     <= (sy2_r & sy3_r) | (syf_r & (sy2_r ^ sy3_r));
			cs_prev_r <= syf_r[0];
		end
	end

	// Receiver: takes one byte per toggle; a full queue holds off the next one.
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST) begin
			ack_r      <= 1'b0;
			rx_valid_r <= 1'b0;
			rx_r       <= '0;
		end else if (rx_valid_r) begin
			rx_valid_r <= !rx_ready;
		end else if (syf_r[1] != ack_r) begin
			rx_r       <= hold_r[ack_r];
			rx_valid_r <= 1'b1;
			ack_r      <= ~ack_r;
		end
	end

	srr_fifo #(
		.WIDTH ($bits(srr_pkg::srr_byte_s)),
		.DEPTH (srr_pkg::FIFO_DEPTH)
	) u_fifo (
		.i_clk   (I_SYS_CLK),
		.i_rst   (I_RST),
		.i_data  (rx_r),
		.i_valid (rx_valid_r),
		.o_ready (rx_ready),
		.o_data  (ev),
		.o_valid (ev_valid),
		.i_ready (eng_ready)
	);

	// Sequencer: blank fill, commit, timed program and reset recovery.
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST) begin
			state_r <= ST_INIT;
			cnt_r   <= 11'h000;
			timer_r <= 32'h0000_0000;
		end else if (do_reset) begin
			state_r <= ST_RECOVER;
			timer_r <= 32'h0000_0000;
		end else begin
			case (state_r)
				ST_INIT: begin
					cnt_r <= cnt_r + 11'h001;
					if (cnt_r == srr_pkg::MEM_LAST) begin
						state_r <= ST_IDLE;
					end
				end
				ST_IDLE: begin
					cnt_r <= 11'h000;
					if (start_commit) begin
						state_r <= ST_COMMIT;
					end
				end
				ST_COMMIT: begin
					cnt_r <= cnt_r + 11'h001;
					timer_r <= 32'h0000_0000;
					if (cnt_r[7:0] == srr_pkg::PAGE_LAST) begin
						state_r <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					timer_r <= timer_r + 32'h0000_0001;
					if (prog_end) begin
						state_r <= ST_IDLE;
					end
				end
				ST_RECOVER: begin
					timer_r <= timer_r + 32'h0000_0001;
					if (timer_r == 32'(srr_pkg::RST_CYCLES - 1)) begin
						state_r <= ST_IDLE;
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// Program command tracking across opcode, address and data bytes.
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST || do_reset) begin
			op_r       <= 8'h00;
			prog_ok_r  <= 1'b0;
			got_r      <= 1'b0;
			pacnt_r    <= 2'h0;
			end_pend_r <= 1'b0;
			end_wait_r <= 2'h0;
		end else begin
			if (syf_r[0] && !cs_prev_r) begin
				end_pend_r <= 1'b1;
				end_wait_r <= 2'h0;
			end else if (end_pend_r && end_wait_r != 2'(srr_pkg::END_SETTLE)) begin
				end_wait_r <= end_wait_r + 2'h1;
			end else if (end_pend_r && !ev_valid && !rx_valid_r) begin
				end_pend_r <= 1'b0;
				prog_ok_r  <= 1'b0;
			end
			if (is_op) begin
				op_r      <= ev.data;
				pacnt_r   <= 2'h0;
				got_r     <= 1'b0;
				prog_ok_r <= ev.data == srr_pkg::OP_PROG_SEC && wel_r && state_r == ST_IDLE;
			end else if (pop && ev.kind == srr_pkg::BK_ADDR && prog_ok_r) begin
				paddr_r <= paddr_full[15:0];
				pacnt_r <= pacnt_r + 2'h1;
				if (pacnt_r == srr_pkg::ADDR_LAST) begin
					psel_r <= srr_pkg::sec_sel(paddr_full);
					page_r <= paddr_full[8];
					bidx_r <= paddr_full[7:0];
					if (srr_pkg::sec_sel(paddr_full) == 2'h0 ||
							lock_r[2'(srr_pkg::sec_sel(paddr_full) - 2'h1)]) begin
						prog_ok_r <= 1'b0;
					end
				end
			end else if (pop && ev.kind == srr_pkg::BK_DATA && prog_ok_r) begin
				bidx_r <= bidx_r + 8'h01;
				got_r  <= 1'b1;
			end
		end
	end

	// Page buffer: at most 256 bytes, later bytes wrap over earlier ones.
	always_ff @(posedge I_SYS_CLK) begin
		if (pop && ev.kind == srr_pkg::BK_DATA && prog_ok_r && pacnt_r == 2'h3) begin
			pbuf_r[bidx_r] <= ev.data;
		end
	end

	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST || do_reset || (is_op && ev.data == srr_pkg::OP_PROG_SEC)) begin
			pval_r <= '0;
		end else if (pop && ev.kind == srr_pkg::BK_DATA && prog_ok_r && pacnt_r == 2'h3) begin
			pval_r[bidx_r] <= 1'b1;
		end else if (state_r == ST_COMMIT) begin
			pval_r[cnt_r[7:0]] <= 1'b0;
		end
	end

	// Array writes; programming can only clear bits, so erased cells take data as sent.
	always_ff @(posedge I_SYS_CLK) begin
		if (state_r == ST_INIT) begin
			mem_r[cnt_r] <= srr_pkg::ERASED_BYTE;
		end else if (state_r == ST_COMMIT && pval_r[cnt_r[7:0]]) begin
			mem_r[{2'(psel_r - 2'h1), page_r, cnt_r[7:0]}] <=
				mem_r[{2'(psel_r - 2'h1), page_r, cnt_r[7:0]}] & pbuf_r[cnt_r[7:0]];
		end
	end

	// Status and volatile settings; lock bits are sticky until power-on reset.
	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST) begin
			wel_r   <= 1'b0;
			sus_r   <= 1'b0;
			armed_r <= 1'b0;
			lock_r  <= 3'h0;
			cont_r  <= srr_pkg::CONT_READ_RST;
			wrap_r  <= srr_pkg::WRAP_RST;
			busy_r  <= 1'b1;
			recov_r <= 1'b0;
			stat_r  <= 7'h40;
		end else begin
			lock_r  <= lock_r | I_OTP_LOCK_SET;
			busy_r  <= state_r == ST_INIT || state_r == ST_COMMIT || state_r == ST_WAIT;
			recov_r <= state_r == ST_RECOVER;
			stat_r  <= {busy_r, wel_r, sus_r, recov_r, lock_r};
			if (do_reset) begin
				wel_r   <= 1'b0;
				sus_r   <= 1'b0;
				armed_r <= 1'b0;
				cont_r  <= srr_pkg::CONT_READ_RST;
				wrap_r  <= srr_pkg::WRAP_RST;
			end else begin
				if (I_VOL_LOAD) begin
					sus_r  <= I_SUSPEND_FLAG;
					cont_r <= I_CONT_READ_BITS;
					wrap_r <= I_WRAP_SETTING_BITS;
				end
				if (is_op) begin
					armed_r <= ev.data == srr_pkg::OP_RST_EN;
				end
				if (prog_end) begin
					wel_r <= 1'b0;
				end else if (is_op && state_r == ST_IDLE && ev.data == srr_pkg::OP_WR_EN) begin
					wel_r <= 1'b1;
				end else if (is_op && state_r == ST_IDLE && ev.data == srr_pkg::OP_WR_DIS) begin
					wel_r <= 1'b0;
				end
			end
		end
	end

	assign O_SO                 = so_r;
	assign O_SO_OE              = so_oe_r;
	assign O_BUSY_FLAG          = busy_r;
	assign O_WRITE_ENABLE_LATCH = wel_r;
	assign O_SUSPEND_FLAG       = sus_r;
	assign O_OTP_LOCK_BITS      = lock_r;
	assign O_CONT_READ_BITS     = cont_r;
	assign O_WRAP_SETTING_BITS  = wrap_r;
	assign O_RECOVERING         = recov_r;
endmodule

// File: tb/srr_host.sv
module srr_host (
	output logic      o_sck,  // Serial clock to the device.
	output logic      o_cs_n, // Chip select, active low.
	output logic      o_si,   // Serial data to the device.
	input  wire logic i_so    // Serial data from the device.
);
	timeunit 1ns;
	timeprecision 100ps;
	// Idle bus: clock parked low, select high.
	initial begin
		o_sck = 1'b0;
		o_cs_n = 1'b1;
		o_si = 1'b1;
	end
	// One whole frame under a single select-low period; bytes are spaced so
	// the device hand-off is never overrun, and the clock stands still between.
	task automatic frame(input logic [63:0] bits, input int n, input int nrd,
		output logic [31:0] rd);
		rd = '0;
		o_cs_n = 1'b0;
		#20;
		for (int i = 0; i < n + nrd * 8; i++) begin
			o_sck = 1'b0;
			o_si = (i < n) ? bits[63 - i] : ~o_si;
			#6;
			o_sck = 1'b1;
			if (i >= n) rd = {rd[30:0], i_so};
			#6;
			if (i % 8 == 7) #130;
		end
		o_sck = 1'b0;
		#6;
		o_cs_n = 1'b1;
		o_si = ~o_si;
		#250;
	endtask
endmodule

// File: tb/srr_top_sva.sv
module srr_top_sva (
	input wire logic       I_SYS_CLK,            // System clock.
	input wire logic       I_RST,                // Reset.
	input wire logic       I_CS_N,               // Chip select, active low.
	input wire logic [2:0] I_OTP_LOCK_SET,       // Lock set pulses.
	input wire logic       O_SO_OE,              // Serial out enable.
	input wire logic       O_BUSY_FLAG,          // Busy.
	input wire logic       O_WRITE_ENABLE_LATCH, // Write enable latch.
	input wire logic       O_SUSPEND_FLAG,       // Suspend.
	input wire logic [2:0] O_OTP_LOCK_BITS,      // Lock bits.
	input wire logic [7:0] O_CONT_READ_BITS,     // Mode bits.
	input wire logic [2:0] O_WRAP_SETTING_BITS,  // Wrap bits.
	input wire logic       O_RECOVERING          // Recovery.
);
	timeunit 1ns;
	timeprecision 100ps;
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	default clocking @(posedge I_SYS_CLK); endclocking
	default disable iff (I_RST);
	int rc_r; // Recovery length in cycles.
	// A counter keeps the long recovery span out of a repetition.
	always_ff @(posedge I_SYS_CLK) begin
		rc_r <= O_RECOVERING ? rc_r + 1 : 0;
	end
	sequence s_prog_go;
		$rose(O_BUSY_FLAG);
	endsequence
	sequence s_rst_go;
		$rose(O_RECOVERING);
	endsequence
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	a_prog_wel: assert property (s_prog_go |-> O_WRITE_ENABLE_LATCH)
		else $error("program began without write enable.");
	a_prog_hold: assert property (s_prog_go |=> (O_BUSY_FLAG || O_RECOVERING)[*8])
		else $error("busy dropped early.");
	a_wel_drop: assert property ($fell(O_BUSY_FLAG) |-> !O_WRITE_ENABLE_LATCH)
		else $error("latch kept after busy.");
	a_lock_set: assert property (|I_OTP_LOCK_SET |=>
		(O_OTP_LOCK_BITS & $past(I_OTP_LOCK_SET)) == $past(I_OTP_LOCK_SET))
		else $error("lock bit not set.");
	a_lock_keep: assert property ($past(O_OTP_LOCK_BITS) ==
		(O_OTP_LOCK_BITS & $past(O_OTP_LOCK_BITS))) else $error("lock bit lost.");
	a_rst_clear: assert property (s_rst_go |-> ##[0:2] (!O_WRITE_ENABLE_LATCH &&
		!O_SUSPEND_FLAG && O_CONT_READ_BITS == 8'h00 && O_WRAP_SETTING_BITS == 3'h0))
		else $error("volatile state kept.");
	a_recov_len: assert property ($fell(O_RECOVERING) |->
		rc_r >= srr_pkg::RST_CYCLES - 1 && rc_r <= srr_pkg::RST_CYCLES + 1)
		else $error("recovery length wrong.");
	a_recov_wel: assert property (O_RECOVERING |-> !$rose(O_WRITE_ENABLE_LATCH))
		else $error("command taken in recovery.");
	a_oe_cs: assert property (I_CS_N |-> !O_SO_OE)
		else $error("output driven while deselected.");
endmodule
bind srr_top srr_top_sva srr_top_sva_inst (.*);

// File: tb/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic I_SYS_CLK = 1'b0, I_RST = 1'b1, I_SCK, I_CS_N, I_SI, O_SO, O_SO_OE, I_VOL_LOAD = 1'b0;
	logic I_SUSPEND_FLAG = 1'b0, O_BUSY_FLAG, O_WRITE_ENABLE_LATCH, O_SUSPEND_FLAG, O_RECOVERING;
	logic [2:0] I_OTP_LOCK_SET = 3'h0, I_WRAP_SETTING_BITS = 3'h0, O_OTP_LOCK_BITS;
	logic [2:0] O_WRAP_SETTING_BITS;
	logic [7:0] I_CONT_READ_BITS = 8'h00, O_CONT_READ_BITS;
	logic [31:0] rd_w;
	int err_total = 0, n_compared = 0;
	// The short program time keeps the run brief.
	srr_top #(.PROG_CYCLES(50)) srr_top_inst (.I_SYS_CLK, .I_RST, .I_SCK, .I_CS_N, .I_SI,
		.O_SO, .O_SO_OE, .I_OTP_LOCK_SET, .I_VOL_LOAD, .I_SUSPEND_FLAG, .I_CONT_READ_BITS,
		.I_WRAP_SETTING_BITS, .O_BUSY_FLAG, .O_WRITE_ENABLE_LATCH, .O_SUSPEND_FLAG,
		.O_OTP_LOCK_BITS, .O_CONT_READ_BITS, .O_WRAP_SETTING_BITS, .O_RECOVERING);
	srr_host srr_host_inst (.o_sck(I_SCK), .o_cs_n(I_CS_N), .o_si(I_SI), .i_so(O_SO));
	// System clock, 25 ns period.
	always #12.5 I_SYS_CLK = ~I_SYS_CLK;
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic test_done;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic op(input logic [7:0] c);
		srr_host_inst.frame({c, 56'h0}, 8, 0, rd_w);
	endtask
	task automatic prog(input logic [23:0] a, input logic [15:0] d);
		srr_host_inst.frame({srr_pkg::OP_PROG_SEC, a, d, 16'h0000}, 48, 0, rd_w);
	endtask
	task automatic rd4(input logic [23:0] a);
		srr_host_inst.frame({srr_pkg::OP_READ_SEC, a, 8'h00, 24'h00_0000}, 40, 4, rd_w);
	endtask
	// Bounded wait for busy or recovery to reach a level.
	task automatic wlvl(input bit rec, input logic v, input int lim);
		for (int k = 0; k < lim && (rec ? O_RECOVERING : O_BUSY_FLAG) !== v; k++)
			@(negedge I_SYS_CLK);
		@(negedge I_SYS_CLK);
		chk(rec ? "recovery" : "busy", {31'h0, rec ? O_RECOVERING : O_BUSY_FLAG}, {31'h0, v});
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_fill;
		chk("busy fill", {31'h0, O_BUSY_FLAG}, 32'h0000_0001);
		wlvl(1'b0, 1'b0, 2000);
		chk("locks", {29'h0, O_OTP_LOCK_BITS}, 32'h0000_0000);
	endtask
	task automatic t_no_wel;
		prog(24'h00_10FF, 16'h5A5A);
		repeat (20) @(negedge I_SYS_CLK);
		chk("busy no latch", {31'h0, O_BUSY_FLAG}, 32'h0000_0000);
	endtask
	task automatic t_prog_wrap;
		op(srr_pkg::OP_WR_EN);
		chk("latch", {31'h0, O_WRITE_ENABLE_LATCH}, 32'h0000_0001);
		srr_host_inst.frame({srr_pkg::OP_RD_SR1, 56'h0}, 8, 1, rd_w);
		chk("status one", rd_w, 32'h0000_0002);
		prog(24'h00_10FF, 16'hA53C);
		wlvl(1'b0, 1'b1, 40);
		wlvl(1'b0, 1'b0, 400);
		chk("latch after", {31'h0, O_WRITE_ENABLE_LATCH}, 32'h0000_0000);
		rd4(24'h00_10FE);
		chk("wrap read", rd_w, 32'hFFA5_3CFF);
	endtask
	// Locked register is refused; a read during a program is ignored.
	task automatic t_lock_busy;
		@(negedge I_SYS_CLK);
		I_OTP_LOCK_SET = 3'h2;
		@(negedge I_SYS_CLK);
		I_OTP_LOCK_SET = 3'h0;
		chk("lock bits", {29'h0, O_OTP_LOCK_BITS}, 32'h0000_0002);
		srr_host_inst.frame({srr_pkg::OP_RD_SR2, 56'h0}, 8, 1, rd_w);
		chk("status two", rd_w, 32'h0000_0010);
		op(srr_pkg::OP_WR_EN);
		prog(24'h00_2000, 16'h1234);
		repeat (20) @(negedge I_SYS_CLK);
		chk("busy locked", {31'h0, O_BUSY_FLAG}, 32'h0000_0000);
		chk("latch kept", {31'h0, O_WRITE_ENABLE_LATCH}, 32'h0000_0001);
		prog(24'h00_3000, 16'h1122);
		wlvl(1'b0, 1'b1, 40);
		rd4(24'h00_3000);
		chk("read busy", rd_w, 32'h0000_0000);
		chk("still busy", {31'h0, O_BUSY_FLAG}, 32'h0000_0001);
		wlvl(1'b0, 1'b0, 400);
		rd4(24'h00_3000);
		chk("reg3", rd_w, 32'h1122_FFFF);
		rd4(24'h00_2000);
		chk("reg2", rd_w, 32'hFFFF_FFFF);
	endtask
	task automatic t_soft_rst;
		@(negedge I_SYS_CLK);
		I_SUSPEND_FLAG = 1'b1;
		I_CONT_READ_BITS = 8'hA5;
		I_WRAP_SETTING_BITS = 3'h5;
		I_VOL_LOAD = 1'b1;
		@(negedge I_SYS_CLK);
		I_VOL_LOAD = 1'b0;
		op(srr_pkg::OP_WR_EN);
		chk("idle", {31'h0, O_BUSY_FLAG}, 32'h0000_0000);
		op(srr_pkg::OP_RST_EN);
		op(srr_pkg::OP_RD_SR1);
		op(srr_pkg::OP_RST_DEV);
		chk("no reset", {28'h0, O_RECOVERING, O_WRAP_SETTING_BITS}, 32'h0000_0005);
		op(srr_pkg::OP_RST_EN);
		op(srr_pkg::OP_RST_DEV);
		chk("cleared", {O_RECOVERING, O_WRITE_ENABLE_LATCH, O_SUSPEND_FLAG, O_CONT_READ_BITS,
			O_WRAP_SETTING_BITS}, 32'h0000_2000);
		op(srr_pkg::OP_WR_EN);
		chk("refused", {31'h0, O_WRITE_ENABLE_LATCH}, 32'h0000_0000);
		wlvl(1'b1, 1'b0, 1300);
		op(srr_pkg::OP_WR_EN);
		chk("taken", {31'h0, O_WRITE_ENABLE_LATCH}, 32'h0000_0001);
		op(srr_pkg::OP_WR_DIS);
		chk("disabled", {31'h0, O_WRITE_ENABLE_LATCH}, 32'h0000_0000);
	endtask
	// Main sequence: reset for five cycles, then each scenario in turn.
	initial begin
		repeat (5) @(posedge I_SYS_CLK);
		@(negedge I_SYS_CLK);
		I_RST = 1'b0;
		@(negedge I_SYS_CLK);
		t_fill;
		t_no_wel;
		t_prog_wrap;
		t_lock_busy;
		t_soft_rst;
		test_done;
	end
	// Watchdog, well beyond the expected run of about 100 us.
	initial begin
		#1_000_000;
		err_total++;
		test_done;
	end
endmodule
